// ### rtl/scg_defines.svh
// Offsets, field positions and reset values of the clock gating block
`ifndef SCG_DEFINES_SVH
`define SCG_DEFINES_SVH

// Block base within the system control space, decoded upstream
`define SCG_BASE_ADDR        32'h400F_E000

// Register byte offsets
`define SCG_OFS_RUN_CFG      12'h060
`define SCG_OFS_RUN_GATE     12'h104
`define SCG_OFS_SLEEP_GATE   12'h114
`define SCG_OFS_DEEP_GATE    12'h124
`define SCG_OFS_FAULT_STAT   12'h1F0

// Gate bit positions
`define SCG_BIT_ASYNC0       0
`define SCG_BIT_ASYNC1       1
`define SCG_BIT_ASYNC2       2
`define SCG_BIT_SYNC0        4
`define SCG_BIT_SYNC1        5
`define SCG_BIT_TWO_WIRE     12
`define SCG_BIT_COUNTER0     16
`define SCG_BIT_COUNTER3     19
`define SCG_BIT_COMPARATOR   24

// Writable gate bits; all others read as zero
`define SCG_GATE_WR_MASK     32'h010F_1037
`define SCG_GATE_RESET       32'h0000_0000

// Run clock configuration fields
`define SCG_CFG_AUTO_BIT     0
`define SCG_CFG_AUTO_RESET   1'b0

// Fault status fields
`define SCG_FLT_STICKY_BIT   0
`define SCG_FLT_UNIT_LSB     8
`define SCG_FLT_MODE_LSB     16

`endif

// ### rtl/scg_pkg.sv
// Types shared by the clock gating block
package scg_pkg;

	// Power mode the gate selection follows
	typedef enum logic [1:0] {
		SCG_MODE_RUN,
		SCG_MODE_SLEEP,
		SCG_MODE_DEEP
	} scg_mode_e;

	// Index of one gating register copy
	typedef logic [1:0] scg_bank_t;

	// One 32-bit register word
	typedef logic [31:0] scg_word_t;

endpackage

// ### rtl/scg_reg_if.sv
// Write port and stored value of one gating register copy
`timescale 1ns/1ps
`default_nettype none

interface scg_reg_if;
	import scg_pkg::*;

	logic      wr_en;   // One-cycle write strobe
	scg_word_t wr_data; // Value to store
	scg_word_t q;       // Stored value, masked

	modport ctl (output wr_en, output wr_data, input q);
	modport store (input wr_en, input wr_data, output q);
endinterface

`default_nettype wire

// ### rtl/scg_gate_reg.sv
// One gating register copy with read-only zero reserved bits
`timescale 1ns/1ps
`default_nettype none
`include "scg_defines.svh"

module scg_gate_reg
	import scg_pkg::*;
#(
	parameter scg_word_t WR_MASK = `SCG_GATE_WR_MASK // Writable bits
) (
	input  wire logic pclk,     // System clock
	input  wire logic presetn,  // Async reset, active low
	scg_reg_if.store  port      // Write strobe and stored value
);

	// Reserved bits can never be stored, so they always read zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port.q <= `SCG_GATE_RESET;
		end else if (port.wr_en) begin
			port.q <= port.wr_data & WR_MASK;
		end
	end

endmodule

`default_nettype wire

// ### rtl/scg_clock_gating.sv
// Peripheral clock gating control for the second group of units
//
// How it works
// - A set gate bit clocks its unit; a clear bit stops and disables it.
// - Access to a unit whose clock is gated returns a bus fault.
// - Reset clears the sleep gating register to zero; all units unclocked.
// - Run, sleep and deep-sleep gating registers share one layout.
// - Auto gating bit makes low-power modes use their own registers.
// - Bit 24 gates the analog comparator.
// - Bits 19 to 16 gate general-purpose counters 3 to 0.
// - Bit 12 gates the two-wire port.
// - Bits 5 and 4 gate synchronous serial ports 1 and 0.
// - Bits 2, 1 and 0 gate asynchronous serial ports 2, 1, 0.
// - Unassigned bits are read-only and read zero.
// - Sleep gating register sits at offset 0x114, 32 bits wide.
//
// Enables leave on registered outputs; the cells that actually stop
// each unit clock sit outside this block and must be glitch free.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "scg_defines.svh"

module scg_clock_gating
	import scg_pkg::*;
#(
	parameter int ADDR_W = 12 // Byte address bits decoded here
) (
	input  wire logic              pclk,          // System clock, 50 MHz
	input  wire logic              presetn,       // Async reset, active low
	input  wire logic              psel,          // APB select
	input  wire logic              penable,       // APB access phase
	input  wire logic              pwrite,        // APB write
	input  wire logic [ADDR_W-1:0] paddr,         // APB byte address
	input  wire logic [31:0]       pwdata,        // APB write data
	output logic      [31:0]       prdata,        // APB read data
	output logic                   pready,        // APB ready
	output logic                   pslverr,       // APB error
	input  wire logic              sleep_mode,    // System is in Sleep
	input  wire logic              deep_mode,     // System is in Deep-Sleep
	input  wire logic              unit_access,   // Bus access to a unit
	input  wire logic [4:0]        unit_index,    // Gate bit of that unit
	output logic      [31:0]       unit_clk_en,   // Clock enable per gate bit
	output logic                   unit_fault,    // Access hit gated unit
	output logic                   unit_grant     // Access may complete
);

	// Register copies: run, sleep, deep-sleep
	localparam int NUM_BANKS = 3;
	localparam scg_bank_t BANK_RUN   = 2'd0;
	localparam scg_bank_t BANK_SLEEP = 2'd1;
	localparam scg_bank_t BANK_DEEP  = 2'd2;

	// Writable gate positions, one per unit behind this register
	localparam scg_word_t GATE_MASK =
		(32'h0000_0001 << `SCG_BIT_COMPARATOR) |
		((32'h0000_0002 << `SCG_BIT_COUNTER3) -
		 (32'h0000_0001 << `SCG_BIT_COUNTER0)) |
		(32'h0000_0001 << `SCG_BIT_TWO_WIRE) |
		(32'h0000_0001 << `SCG_BIT_SYNC1) |
		(32'h0000_0001 << `SCG_BIT_SYNC0) |
		(32'h0000_0001 << `SCG_BIT_ASYNC2) |
		(32'h0000_0001 << `SCG_BIT_ASYNC1) |
		(32'h0000_0001 << `SCG_BIT_ASYNC0);

	scg_reg_if gate_bank [NUM_BANKS] ();

	// Bus answer registers
	logic [31:0] prdata_ff;
	logic        pready_ff;
	logic        pslverr_ff;
	logic [31:0] nxt_prdata;
	logic        nxt_pslverr;

	// Gate selection state
	logic        auto_gate_ff;
	scg_mode_e   mode_ff;
	scg_mode_e   nxt_mode;
	logic [31:0] clk_en_ff;
	logic [31:0] nxt_clk_en;

	// Unit access answer and fault capture
	logic        fault_ff;
	logic        grant_ff;
	logic        fault_sticky_ff;
	logic [4:0]  fault_unit_ff;
	scg_mode_e   fault_mode_ff;

	// Bus phase and address decode
	logic        setup_phase;
	logic        wr_commit;
	logic        hit_cfg;
	logic        hit_flt;
	logic        hit_run;
	logic        hit_sleep;
	logic        hit_deep;
	logic        addr_hit;

	// Gate lookup and fault status
	logic        unit_gated;
	logic        fault_clr;
	logic [31:0] fault_word;

	// Setup phase is where the answer is prepared
	assign setup_phase = psel && !penable;

	// Writes land only at the edge that completes the access phase
	assign wr_commit = psel && penable && pready_ff && pwrite;

	// Address decode on the low byte address bits
	assign hit_cfg   = (paddr == ADDR_W'(`SCG_OFS_RUN_CFG));
	assign hit_run   = (paddr == ADDR_W'(`SCG_OFS_RUN_GATE));
	assign hit_sleep = (paddr == ADDR_W'(`SCG_OFS_SLEEP_GATE));
	assign hit_deep  = (paddr == ADDR_W'(`SCG_OFS_DEEP_GATE));
	assign hit_flt   = (paddr == ADDR_W'(`SCG_OFS_FAULT_STAT));
	assign addr_hit  = hit_cfg | hit_run | hit_sleep | hit_deep | hit_flt;

	// Three identical copies, one store module each
	genvar gi;
	generate
		for (gi = 0; gi < NUM_BANKS; gi++) begin : g_bank
			scg_gate_reg #(
				.WR_MASK (GATE_MASK)
			) u_gate_reg (
				.pclk    (pclk),
				.presetn (presetn),
				.port    (gate_bank[gi])
			);
		end
	endgenerate

	// Write strobes; data is the bus word, masking happens in the store
	assign gate_bank[BANK_RUN].wr_en     = wr_commit && hit_run;
	assign gate_bank[BANK_RUN].wr_data   = pwdata;
	assign gate_bank[BANK_SLEEP].wr_en   = wr_commit && hit_sleep;
	assign gate_bank[BANK_SLEEP].wr_data = pwdata;
	assign gate_bank[BANK_DEEP].wr_en    = wr_commit && hit_deep;
	assign gate_bank[BANK_DEEP].wr_data  = pwdata;

	// Auto gating select bit of the run clock configuration
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			auto_gate_ff <= `SCG_CFG_AUTO_RESET;
		end else if (wr_commit && hit_cfg) begin
			auto_gate_ff <= pwdata[`SCG_CFG_AUTO_BIT];
		end
	end

	// Fault status word as software sees it
	// Lets software find which access hit a stopped unit
	always_comb begin
		fault_word = 32'h0000_0000;
		fault_word[`SCG_FLT_STICKY_BIT] = fault_sticky_ff;
		fault_word[`SCG_FLT_UNIT_LSB +: 5] = fault_unit_ff;
		fault_word[`SCG_FLT_MODE_LSB +: 2] = fault_mode_ff;
	end

	// Read mux; unmapped addresses read zero and flag an error
	// Data stays zero outside a read answer, so an upstream OR mux is safe
	always_comb begin
		nxt_prdata  = 32'h0000_0000;
		nxt_pslverr = !addr_hit;
		case (1'b1)
			hit_cfg: begin
				nxt_prdata[`SCG_CFG_AUTO_BIT] = auto_gate_ff;
			end
			hit_run: begin
				nxt_prdata = gate_bank[BANK_RUN].q;
			end
			hit_sleep: begin
				nxt_prdata = gate_bank[BANK_SLEEP].q;
			end
			hit_deep: begin
				nxt_prdata = gate_bank[BANK_DEEP].q;
			end
			hit_flt: begin
				nxt_prdata = fault_word;
			end
			default: begin
				nxt_prdata = 32'h0000_0000;
			end
		endcase
		if (!setup_phase || pwrite) begin
			nxt_prdata = 32'h0000_0000;
		end
	end

	// One-wait-free answer: pready rises in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
		end else begin
			pready_ff  <= setup_phase;
			pslverr_ff <= setup_phase && nxt_pslverr;
			prdata_ff  <= nxt_prdata;
		end
	end

	// Mode follows the system; deep-sleep outranks sleep
	always_comb begin
		if (deep_mode) begin
			nxt_mode = SCG_MODE_DEEP;
		end else if (sleep_mode) begin
			nxt_mode = SCG_MODE_SLEEP;
		end else begin
			nxt_mode = SCG_MODE_RUN;
		end
	end

	// Mode taken once so the whole enable word switches on one edge;
	// a mode pulse shorter than a clock cycle may be missed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_ff <= SCG_MODE_RUN;
		end else begin
			mode_ff <= nxt_mode;
		end
	end

	// Without auto gating the run copy stays in force in every mode
	always_comb begin
		case (mode_ff)
			SCG_MODE_SLEEP: begin
				nxt_clk_en = auto_gate_ff ? gate_bank[BANK_SLEEP].q
				                          : gate_bank[BANK_RUN].q;
			end
			SCG_MODE_DEEP: begin
				nxt_clk_en = auto_gate_ff ? gate_bank[BANK_DEEP].q
				                          : gate_bank[BANK_RUN].q;
			end
			SCG_MODE_RUN: begin
				nxt_clk_en = gate_bank[BANK_RUN].q;
			end
			default: begin
				nxt_clk_en = gate_bank[BANK_RUN].q;
			end
		endcase
	end

	// Registered enables keep glitches off the unit clock gates
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_en_ff <= `SCG_GATE_RESET;
		end else begin
			clk_en_ff <= nxt_clk_en & GATE_MASK;
		end
	end

	// Reserved positions have no unit behind them, so they fault too
	// A stray index reads a zero enable, so it can never be granted
	assign unit_gated = !clk_en_ff[unit_index];

	// Access verdict one cycle after the request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_ff <= 1'b0;
			grant_ff <= 1'b0;
		end else begin
			fault_ff <= unit_access && unit_gated;
			grant_ff <= unit_access && !unit_gated;
		end
	end

	// Write one to the sticky bit clears it
	assign fault_clr = wr_commit && hit_flt && pwdata[`SCG_FLT_STICKY_BIT];

	// Sticky fault flag; a new fault beats a clear in the same cycle
	// so a clear racing an access can never hide that fault
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_sticky_ff <= 1'b0;
		end else if (unit_access && unit_gated) begin
			fault_sticky_ff <= 1'b1;
		end else if (fault_clr) begin
			fault_sticky_ff <= 1'b0;
		end
	end

	// Capture which unit faulted and in what mode, latest wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_unit_ff <= 5'h00;
			fault_mode_ff <= SCG_MODE_RUN;
		end else if (unit_access && unit_gated) begin
			fault_unit_ff <= unit_index;
			fault_mode_ff <= mode_ff;
		end
	end

	// All outputs straight from flip-flops
	assign prdata      = prdata_ff;
	assign pready      = pready_ff;
	assign pslverr     = pslverr_ff;
	assign unit_clk_en = clk_en_ff;
	assign unit_fault  = fault_ff;
	assign unit_grant  = grant_ff;

endmodule

`default_nettype wire

// ### bench/scg_clock_gating_props.sv
// Port-level checks on the clock gating block
`timescale 1ns/1ps
`default_nettype none
`include "scg_defines.svh"

module scg_clock_gating_props #(
	parameter int ADDR_W = 12 // Decoded address bits
) (
	input wire logic              pclk,        // Clock
	input wire logic              presetn,     // Reset, low
	input wire logic              psel,        // Select
	input wire logic              penable,     // Access phase
	input wire logic              pwrite,      // Write
	input wire logic [ADDR_W-1:0] paddr,       // Address
	input wire logic [31:0]       pwdata,      // Write data
	input wire logic [31:0]       prdata,      // Read data
	input wire logic              pready,      // Ready
	input wire logic              pslverr,     // Error
	input wire logic              sleep_mode,  // Sleep
	input wire logic              deep_mode,   // Deep-Sleep
	input wire logic              unit_access, // Unit access
	input wire logic [4:0]        unit_index,  // Unit bit
	input wire logic [31:0]       unit_clk_en, // Enables
	input wire logic              unit_fault,  // Fault
	input wire logic              unit_grant   // Grant
);
	logic hit_ff; // Gate bit seen by the previous access

	// Keep the addressed enable so the answer can be judged a cycle on
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hit_ff <= 1'b0;
		end else begin
			hit_ff <= unit_clk_en[unit_index];
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_rsvd_zero: assert property (
		(unit_clk_en & ~`SCG_GATE_WR_MASK) == 32'h0000_0000)
		else $error("reserved enable bit set");
	chk_ready_access: assert property (
		psel && penable |-> pready) else $error("no ready in access");
	chk_ready_idle: assert property (
		!(psel && penable) |-> !pready) else $error("stray ready");
	chk_err_ready: assert property (
		pslverr |-> pready) else $error("error without ready");
	chk_rdata_idle: assert property (
		!pready |-> prdata == 32'h0000_0000) else $error("read data idle");
	chk_resp_one: assert property (
		unit_access |=> unit_fault != unit_grant) else $error("bad answer");
	chk_resp_idle: assert property (
		!unit_access |=> !unit_fault && !unit_grant) else $error("stray answer");
	chk_grant_match: assert property (
		unit_access && $stable(unit_clk_en) |=> unit_grant == hit_ff)
		else $error("grant disagrees with gate");
endmodule

`default_nettype wire

// ### bench/scg_unit_model.sv
// Peripheral units that issue bus accesses and watch the answer
`timescale 1ns/1ps
`default_nettype none

module scg_unit_model (
	input  wire logic       pclk,        // System clock
	input  wire logic       unit_fault,  // Gated unit hit
	input  wire logic       unit_grant,  // Clocked unit hit
	output logic            unit_access, // Access pulse
	output logic [4:0]      unit_index   // Target gate bit
);
	initial begin
		unit_access = 1'b0;
		unit_index  = 5'h00;
	end

	// One access pulse; the answer is read one edge later, settled
	task automatic touch(input logic [4:0] idx, output logic [1:0] resp);
		@(posedge pclk);
		unit_access <= 1'b1;
		unit_index  <= idx;
		@(posedge pclk);
		unit_access <= 1'b0;
		unit_index  <= ~idx; // Index means nothing outside a pulse
		#1;
		resp = {unit_fault, unit_grant};
	endtask
endmodule

`default_nettype wire

// ### bench/sleep_mode_clock_gating_reg1_bench.sv
// Self-checking bench for the clock gating block
`timescale 1ns/1ps
`default_nettype none
`include "scg_defines.svh"

module sleep_mode_clock_gating_reg1_bench;
	import scg_pkg::*;

	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        sleep_mode, deep_mode, unit_access, unit_fault;
	logic        unit_grant, err, au;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, unit_clk_en, rd, d;
	logic [4:0]  unit_index;
	logic [1:0]  resp;
	scg_word_t   exp_gate [3];
	logic [11:0] ofs [3];
	int          bad_count, samples_checked;

	scg_clock_gating dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sleep_mode(sleep_mode),
		.deep_mode(deep_mode), .unit_access(unit_access),
		.unit_index(unit_index), .unit_clk_en(unit_clk_en),
		.unit_fault(unit_fault), .unit_grant(unit_grant));
	scg_unit_model um (.pclk(pclk), .unit_fault(unit_fault),
		.unit_grant(unit_grant), .unit_access(unit_access),
		.unit_index(unit_index));

	// Free-running 50 MHz clock
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	// Hang guard, well past the expected run length
	initial begin
		repeat (20000) @(posedge pclk);
		bad_count++;
		results();
	end

	// Enable pattern the selection should show
	function automatic scg_word_t pick(logic a, logic s, logic dp);
		if (a && dp) return exp_gate[2];
		if (a && s) return exp_gate[1];
		return exp_gate[0];
	endfunction

	task automatic check(input string n, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask

	// One APB transfer, held until ready is sampled high
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] wd, output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		// Waits as long as it takes; only the watchdog ends a hang
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic results();
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		{presetn, psel, penable, pwrite, sleep_mode, deep_mode} = '0;
		paddr = '0;
		pwdata = '0;
		ofs = '{`SCG_OFS_RUN_GATE, `SCG_OFS_SLEEP_GATE, `SCG_OFS_DEEP_GATE};
		void'($urandom(28));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			apb(1'b0, ofs[i], '0, rd, err);
			check("reset_word", '0, rd);
		end
		check("reset_en", '0, unit_clk_en);
		$display("reset test done");
		// All ones first, then random words; software enables units
		for (int k = 0; k < 12; k++) begin
			d = (k < 3) ? 32'hFFFF_FFFF : $urandom();
			apb(1'b1, ofs[k % 3], d, rd, err);
			exp_gate[k % 3] = d & `SCG_GATE_WR_MASK;
			apb(1'b0, ofs[k % 3], '0, rd, err);
			check("gate_word", exp_gate[k % 3], rd);
		end
		// Read-modify-write of the sleep copy
		apb(1'b0, ofs[1], '0, rd, err);
		check("rmw_read", exp_gate[1], rd);
		apb(1'b1, ofs[1], rd | 32'h0000_0010, rd, err);
		exp_gate[1] = exp_gate[1] | 32'h0000_0010;
		apb(1'b1, 12'h200, 32'hFFFF_FFFF, rd, err);
		check("unmapped_err", 32'h1, {31'h0, err});
		apb(1'b0, 12'h200, '0, rd, err);
		check("unmapped_rd", 32'h0, rd);
		check("unmapped_rerr", 32'h1, {31'h0, err});
		$display("register test done");
		// Every mode with auto gating off and on, every gate bit touched
		for (int c = 0; c < 6; c++) begin
			au = c[0];
			apb(1'b1, `SCG_OFS_RUN_CFG, {31'h0, au}, rd, err);
			sleep_mode <= (c / 2) == 1;
			deep_mode  <= (c / 2) == 2;
			repeat (4) @(posedge pclk);
			#1;
			d = pick(au, (c / 2) == 1, (c / 2) == 2);
			check("clk_en", d, unit_clk_en);
			for (int j = 0; j < 32; j++) begin
				um.touch(j[4:0], resp);
				check("unit_resp", d[j] ? 2'b01 : 2'b10, resp);
			end
		end
		$display("gating test done");
		// Last access hit reserved bit 31 in Deep-Sleep, so it faulted
		d = (32'h0000_0001 << `SCG_FLT_STICKY_BIT)
			| (32'h0000_001F << `SCG_FLT_UNIT_LSB)
			| (32'(SCG_MODE_DEEP) << `SCG_FLT_MODE_LSB);
		apb(1'b0, `SCG_OFS_FAULT_STAT, '0, rd, err);
		check("fault_stat", d, rd);
		apb(1'b1, `SCG_OFS_FAULT_STAT, 32'h0000_0001, rd, err);
		apb(1'b0, `SCG_OFS_FAULT_STAT, '0, rd, err);
		d = d & ~(32'h0000_0001 << `SCG_FLT_STICKY_BIT);
		check("fault_clear", d, rd);
		$display("fault test done");
		// Mid-run reset must clear the sleep copy and the enables again
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, ofs[1], '0, rd, err);
		check("rerst_word", '0, rd);
		check("rerst_en", '0, unit_clk_en);
		$display("second reset test done");
		results();
	end
endmodule

bind scg_clock_gating scg_clock_gating_props #(.ADDR_W(ADDR_W)) u_props (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .sleep_mode(sleep_mode),
	.deep_mode(deep_mode), .unit_access(unit_access),
	.unit_index(unit_index), .unit_clk_en(unit_clk_en),
	.unit_fault(unit_fault), .unit_grant(unit_grant));

`default_nettype wire
